// >>> uae_uart.sv
`timescale 1ns/1ns
// Overview of operation
// - Overrun flagged when a new character lands while buffer is unread.
// - On overrun the new character still overwrites the receive buffer.
// - Overrun raises no receive-complete request.
// - Errors are judged at the shift-to-buffer transfer.
// - Framing error when fewer high stop bits than configured.
// - Overrun and framing cleared by disabled mode or receive enable low.
// - Parity error when ones count mismatches chosen even/odd parity.
// - Parity error cleared by reading the receive buffer low byte.
// - Error-sum is the OR of overrun, framing and parity.
// - Receive enable off then on reinitialises buffer and errors.
// - Disabled mode resets transmit buffer; transmit enable before new data.
// - With CTS on, transfers start only while the CTS input is low.
// - CTS sampled only at character start; current character completes.
// - With RTS on, RTS goes low when receiver is ready.
// - RTS returns high on a falling transfer-clock edge once receiving.
// - Flow pin is GPIO, CTS input or RTS output.
// - Sleep mode accepts every address character, and data only once this node is addressed.
// - Data inversion on transmit-buffer write and receive-buffer read.
// - Polarity reversal inverts TxD drive and RxD sample.
// - Bus collision compares TxD with RxD at rising transfer clock.
// - Delay bits read zero and are locked while digital delay select is zero.
// - Frame is start, data LSB first, optional parity, one or two stops.
// - Bit rate is the divider output divided by 16.
// - Divider source is f1, f8, f32 or the external clock pin.
module uae_uart
  import uae_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial line
  input wire logic channel2ReceivePin,
  input wire logic transferClockPin,
  output logic channel2TransmitPinOut,
  output logic channel2TransmitPinOe,
  // Flow-control pin, three-signal form
  input wire logic flowPinIn,
  output logic flowPinOut,
  output logic flowPinOe,
  // Events
  output logic rxRequest,
  output logic txRequest,
  output logic collisionRequest
);
  logic [MODE_W-1:0] mode_ff;
  logic [1:0] ctrl_ff;
  logic [7:0] brg_ff, brgCnt_ff, addr_ff, gpio_ff;
  logic [2:0] dl_ff;
  logic [8:0] txBuf_ff, rxBuf_ff;
  logic txFull_ff, rxFull_ff, rxReq_ff, txReq_ff, colReq_ff, awake_ff;
  uae_err_t err_ff;
  logic [2:0] rxSync_ff, ckSync_ff, ctsSync_ff;
  logic [4:0] preCnt_ff;
  logic [3:0] txOs_ff, rxOs_ff;
  logic [3:0] txCnt_ff, rxCnt_ff;
  logic [11:0] txSh_ff;
  logic [12:0] rxSh_ff;
  logic rxHi_ff, rtsHigh_ff, ctsLvl_ff, rxLvl_ff, ckLvl_ff;
  uae_state_t txSt_ff, rxSt_ff;
  logic apWr_ff, apRd_ff;
  logic [7:0] apAddr_ff;

  logic [2:0] modeSel;
  logic [1:0] flow, ckSrc;
  logic enabled, parEn, stop2, rxLine, srcTick, brgTick, txTick, rxSample;
  logic [3:0] dataBits, txBits, rxBits;
  logic wrEn, rdEn, rxbRead;
  logic [31:0] wdat;

  assign modeSel = mode_ff[MODE_SEL_LSB +: 3];
  assign flow = mode_ff[MODE_FLOW_LSB +: 2];
  assign ckSrc = mode_ff[MODE_CKSRC_LSB +: 2];
  assign enabled = (modeSel != MODE_DISABLED);
  assign parEn = mode_ff[MODE_PAR_EN];
  assign stop2 = mode_ff[MODE_STOP2];
  assign dataBits = (modeSel == MODE_UART7) ? 4'h7 : (modeSel == MODE_UART9) ? 4'h9 : 4'h8;
  assign txBits = 4'h1 + dataBits + {3'h0, parEn} + (stop2 ? 4'h2 : 4'h1);
  assign rxBits = 4'h1 + dataBits + {3'h0, parEn} + (stop2 ? 4'h2 : 4'h1);
  assign wdat = hwdata;

  // AHB-Lite: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always_ff @(posedge clk) begin
    if (reset) begin
      apWr_ff <= 1'b0;
      apRd_ff <= 1'b0;
      apAddr_ff <= 8'h00;
    end else if (hready) begin
      apWr_ff <= hsel && htrans[1] && hwrite;
      apRd_ff <= hsel && htrans[1] && !hwrite;
      apAddr_ff <= haddr;
    end
  end
  assign wrEn = apWr_ff;
  assign rdEn = hsel && htrans[1] && !hwrite && hready;
  assign rxbRead = apRd_ff && (apAddr_ff == OFF_RXB);

  // Input synchronisers: three stages, change accepted when last two agree
  always_ff @(posedge clk) begin
    if (reset) begin
      rxSync_ff <= 3'h7;
      ckSync_ff <= 3'h0;
      ctsSync_ff <= 3'h7;
      rxLvl_ff <= 1'b1;
      ckLvl_ff <= 1'b0;
      ctsLvl_ff <= 1'b1;
    end else begin
      rxSync_ff <= {rxSync_ff[1:0], channel2ReceivePin};
      ckSync_ff <= {ckSync_ff[1:0], transferClockPin};
      ctsSync_ff <= {ctsSync_ff[1:0], flowPinIn};
      if (rxSync_ff[1] == rxSync_ff[2]) rxLvl_ff <= rxSync_ff[2];
      if (ckSync_ff[1] == ckSync_ff[2]) ckLvl_ff <= ckSync_ff[2];
      if (ctsSync_ff[1] == ctsSync_ff[2]) ctsLvl_ff <= ctsSync_ff[2];
    end
  end
  assign rxLine = rxLvl_ff ^ mode_ff[MODE_PINV];

  always_ff @(posedge clk) begin
    if (reset) preCnt_ff <= 5'h00;
    else preCnt_ff <= preCnt_ff + 5'h01;
  end
  logic ckPrev_ff;
  always_ff @(posedge clk) begin
    if (reset) ckPrev_ff <= 1'b0;
    else ckPrev_ff <= ckLvl_ff;
  end
  always_comb begin
    case (ckSrc)
      CK_F1: srcTick = 1'b1;
      CK_F8: srcTick = (preCnt_ff[2:0] == DIV8_MAX[2:0]);
      CK_F32: srcTick = (preCnt_ff == DIV32_MAX);
      CK_EXT: srcTick = ckLvl_ff && !ckPrev_ff;
      default: srcTick = 1'b0;
    endcase
  end
  // Divider counts n+1 source ticks
  always_ff @(posedge clk) begin
    if (reset || !enabled) brgCnt_ff <= 8'h00;
    else if (srcTick) brgCnt_ff <= (brgCnt_ff == 8'h00) ? brg_ff : brgCnt_ff - 8'h01;
  end
  assign brgTick = srcTick && (brgCnt_ff == 8'h00);

  always_ff @(posedge clk) begin
    if (reset || !enabled) txOs_ff <= 4'h0;
    else if (brgTick) txOs_ff <= txOs_ff + 4'h1;
  end
  assign txTick = brgTick && (txOs_ff == OVERSAMPLE_MAX);

  // Register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_ff <= '0;
      ctrl_ff <= 2'h0;
      brg_ff <= 8'h00;
      addr_ff <= 8'h00;
      gpio_ff <= 8'h00;
      dl_ff <= SMR3_DL_RESET;
    end else begin
      if (wrEn && apAddr_ff == OFF_MODE) mode_ff <= wdat[MODE_W-1:0];
      if (wrEn && apAddr_ff == OFF_CTRL) ctrl_ff <= wdat[1:0];
      if (wrEn && apAddr_ff == OFF_BRG) brg_ff <= wdat[7:0];
      if (wrEn && apAddr_ff == OFF_ADDR) begin
        addr_ff <= wdat[7:0];
        gpio_ff <= wdat[15:8];
      end
      // delay bits locked while digital delay off
      if (!mode_ff[MODE_SDA_DIGITAL_DELAY_SELECT]) dl_ff <= SMR3_DL_RESET;
      else if (wrEn && apAddr_ff == OFF_SMR3) dl_ff <= wdat[7:5];
    end
  end

  // Transmitter
  logic ctsOk;
  assign ctsOk = (flow != FLOW_CTS) || !ctsLvl_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      txSt_ff <= ST_IDLE;
      txSh_ff <= 12'hFFF;
      txCnt_ff <= 4'h0;
      txFull_ff <= 1'b0;
      txBuf_ff <= 9'h000;
      txReq_ff <= 1'b0;
    end else if (!enabled) begin
      txSt_ff <= ST_IDLE;
      txSh_ff <= 12'hFFF;
      txFull_ff <= 1'b0;
      txReq_ff <= 1'b0;
    end else begin
      case (txSt_ff)
        ST_IDLE: begin
          // CTS checked only here, at character start
          if (txTick && txFull_ff && ctrl_ff[CTRL_TE] && ctsOk) begin
            // start low, data LSB first, parity, stops high
            txSh_ff <= ({3'h0, txBuf_ff} << 1) | (12'hFFF << (dataBits + 4'h1));
            if (parEn) txSh_ff[dataBits + 4'h1] <= ^(txBuf_ff & ~(9'h1FF << dataBits))
              ^ mode_ff[MODE_PAR_ODD];
            txSh_ff[0] <= 1'b0;
            txCnt_ff <= txBits - 4'h1;
            txFull_ff <= 1'b0;
            txSt_ff <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (txTick) begin
            txSh_ff <= {1'b1, txSh_ff[11:1]};
            txCnt_ff <= txCnt_ff - 4'h1;
            if (txCnt_ff == 4'h0) begin
              txSh_ff <= 12'hFFF;
              txSt_ff <= ST_IDLE;
              txReq_ff <= 1'b1;
            end
          end
        end
        default: txSt_ff <= ST_IDLE;
      endcase
      // writes need transmit enable; invert on write; set wins over a load
      if (wrEn && apAddr_ff == OFF_TXB && ctrl_ff[CTRL_TE]) begin
        txBuf_ff <= mode_ff[MODE_DINV] ? ~wdat[8:0] : wdat[8:0];
        txFull_ff <= 1'b1;
      end
      if (txReq_ff && !(txTick && txCnt_ff == 4'h0 && txSt_ff == ST_DATA)) txReq_ff <= 1'b0;
    end
  end
  // transmit polarity; open drain, driven only for low
  always_comb begin
    channel2TransmitPinOut = 1'b0;
    channel2TransmitPinOe = !(txSh_ff[0] ^ mode_ff[MODE_PINV]);
  end

  // Receiver
  logic [3:0] lastIdx;
  logic stopsOk, parBad, rxDone;
  logic [8:0] rxData;
  assign lastIdx = rxBits - 4'h1;
  assign rxDone = (rxSt_ff == ST_DATA) && rxSample && (rxCnt_ff == lastIdx);
  assign rxSample = brgTick && (rxOs_ff == SAMPLE_MID);
  always_comb begin
    rxData = {rxSh_ff[9:1]} & ~(9'h1FF << dataBits);
    stopsOk = stop2 ? (rxLine && rxSh_ff[rxBits - 4'h2]) : rxLine;
    parBad = parEn && ((^rxData) ^ rxSh_ff[dataBits + 4'h1] ^ mode_ff[MODE_PAR_ODD]);
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      rxSt_ff <= ST_IDLE;
      rxOs_ff <= 4'h0;
      rxCnt_ff <= 4'h0;
      rxSh_ff <= '0;
      rxHi_ff <= 1'b0;
    end else if (!enabled || !ctrl_ff[CTRL_RE]) begin
      rxSt_ff <= ST_IDLE;
      rxOs_ff <= 4'h0;
      rxHi_ff <= 1'b0;
    end else begin
      case (rxSt_ff)
        ST_IDLE: begin
          if (brgTick && !rxLine) begin
            rxOs_ff <= 4'h1;
            rxCnt_ff <= 4'h0;
            rxSt_ff <= ST_START;
          end
        end
        ST_START, ST_DATA: begin
          if (brgTick) rxOs_ff <= rxOs_ff + 4'h1;
          // RTS high at falling half of transfer clock
          if (brgTick && rxOs_ff == OVERSAMPLE_MAX) rxHi_ff <= 1'b1;
          if (rxSample) begin
            rxSh_ff[rxCnt_ff] <= rxLine;
            rxCnt_ff <= rxCnt_ff + 4'h1;
            if (rxSt_ff == ST_START && rxLine) rxSt_ff <= ST_IDLE;
            else rxSt_ff <= ST_DATA;
            if (rxDone) begin
              rxSt_ff <= ST_IDLE;
              rxHi_ff <= 1'b0;
            end
          end
        end
        default: rxSt_ff <= ST_IDLE;
      endcase
    end
  end

  // judged at buffer transfer; sleep filter
  logic accept, isAddr;
  assign isAddr = rxData[dataBits - 4'h1];
  assign accept = rxDone && (!mode_ff[MODE_SLEEP] || awake_ff || isAddr);
  always_ff @(posedge clk) begin
    if (reset) begin
      rxBuf_ff <= 9'h000;
      rxFull_ff <= 1'b0;
      rxReq_ff <= 1'b0;
      err_ff <= '0;
      awake_ff <= 1'b0;
    end else if (!enabled || !ctrl_ff[CTRL_RE]) begin
      rxFull_ff <= 1'b0;
      rxReq_ff <= 1'b0;
      err_ff <= '0;
      awake_ff <= 1'b0;
    end else begin
      rxReq_ff <= 1'b0;
      if (accept && mode_ff[MODE_SLEEP] && isAddr)
        awake_ff <= ((rxData[7:0] & ~(8'hFF << (dataBits - 4'h1)))
          == (addr_ff & ~(8'hFF << (dataBits - 4'h1))));
      // parity cleared by low-byte read; set wins
      if (rxbRead) begin
        err_ff.par <= 1'b0;
        rxFull_ff <= 1'b0;
      end
      if (accept) begin
        rxBuf_ff <= rxData;
        rxFull_ff <= 1'b1;
        if (rxFull_ff && !rxbRead) err_ff.ovr <= 1'b1;
        else rxReq_ff <= 1'b1;
        if (!stopsOk) err_ff.frm <= 1'b1;
        if (parBad) err_ff.par <= 1'b1;
      end
    end
  end

  // RTS low when ready; pin role
  always_comb begin
    flowPinOut = gpio_ff[0];
    flowPinOe = gpio_ff[1];
    if (flow == FLOW_RTS) begin
      flowPinOut = !(enabled && ctrl_ff[CTRL_RE] && !rxHi_ff);
      flowPinOe = 1'b1;
    end else if (flow == FLOW_CTS) begin
      flowPinOe = 1'b0;
    end
  end

  logic txLvl;
  assign txLvl = txSh_ff[0] ^ mode_ff[MODE_PINV];
  always_ff @(posedge clk) begin
    if (reset || !enabled) colReq_ff <= 1'b0;
    else colReq_ff <= mode_ff[MODE_BCD] && txTick && (txSt_ff == ST_DATA)
      && (txLvl != rxLvl_ff);
  end
  assign rxRequest = rxReq_ff;
  assign txRequest = txReq_ff;
  assign collisionRequest = colReq_ff;

  // Read data registered; errors with data; sum; invert on read
  logic sum;
  assign sum = err_ff.ovr | err_ff.frm | err_ff.par;
  always_ff @(posedge clk) begin
    if (reset) hrdata <= 32'h0;
    else if (rdEn) begin
      case (haddr)
        OFF_MODE: hrdata <= {16'h0, mode_ff};
        OFF_CTRL: hrdata <= {30'h0, ctrl_ff};
        OFF_BRG: hrdata <= {24'h0, brg_ff};
        OFF_TXB: hrdata <= {23'h0, txBuf_ff};
        OFF_RXB: hrdata <= {16'h0, sum, err_ff.par, err_ff.frm, err_ff.ovr, 3'h0,
          mode_ff[MODE_DINV] ? ~rxBuf_ff : rxBuf_ff};
        OFF_STAT: hrdata <= {24'h0, ctsLvl_ff, awake_ff, sum, txFull_ff, rxFull_ff,
          txSt_ff == ST_IDLE, rxSt_ff != ST_IDLE, !txFull_ff};
        OFF_ADDR: hrdata <= {16'h0, gpio_ff, addr_ff};
        OFF_SMR3: hrdata <= {24'h0, mode_ff[MODE_SDA_DIGITAL_DELAY_SELECT] ? dl_ff : 3'h0, 5'h00};
        default: hrdata <= 32'h0;
      endcase
    end
  end
endmodule : uae_uart

// >>> uae_pkg.sv
package uae_pkg;
  // Register byte offsets (AHB-Lite, one word each)
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_BRG = 8'h08;
  localparam logic [7:0] OFF_TXB = 8'h0C;
  localparam logic [7:0] OFF_RXB = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_ADDR = 8'h18;
  localparam logic [7:0] OFF_SMR3 = 8'h1C;
  // Mode register fields
  localparam int MODE_SEL_LSB = 0;
  localparam logic [2:0] MODE_DISABLED = 3'h0;
  localparam logic [2:0] MODE_UART7 = 3'h4;
  localparam logic [2:0] MODE_UART8 = 3'h5;
  localparam logic [2:0] MODE_UART9 = 3'h6;
  localparam int MODE_CKSRC_LSB = 3;
  localparam int MODE_STOP2 = 5;
  localparam int MODE_PAR_ODD = 6;
  localparam int MODE_PAR_EN = 7;
  localparam int MODE_FLOW_LSB = 8;
  localparam int MODE_SLEEP = 10;
  localparam int MODE_DINV = 11;
  localparam int MODE_PINV = 12;
  localparam int MODE_BCD = 13;
  localparam int MODE_SIM = 14;
  localparam int MODE_SDA_DIGITAL_DELAY_SELECT = 15;
  localparam int MODE_W = 16;
  // Control register
  localparam int CTRL_TE = 0;
  localparam int CTRL_RE = 1;
  // Flow pin options
  localparam logic [1:0] FLOW_GPIO = 2'h0;
  localparam logic [1:0] FLOW_CTS = 2'h1;
  localparam logic [1:0] FLOW_RTS = 2'h2;
  // Count source select
  localparam logic [1:0] CK_F1 = 2'h0;
  localparam logic [1:0] CK_F8 = 2'h1;
  localparam logic [1:0] CK_F32 = 2'h2;
  localparam logic [1:0] CK_EXT = 2'h3;
  localparam logic [4:0] DIV8_MAX = 5'h07;
  localparam logic [4:0] DIV32_MAX = 5'h1F;
  localparam logic [3:0] OVERSAMPLE_MAX = 4'hF;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  // Receive buffer read fields
  localparam int RXB_OVR = 12;
  localparam int RXB_FRM = 13;
  localparam int RXB_PAR = 14;
  localparam int RXB_SUM = 15;
  localparam logic [2:0] SMR3_DL_RESET = 3'h0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA = 4'b0100,
    ST_STOP = 4'b1000
  } uae_state_t;

  typedef struct packed {
    logic ovr;
    logic frm;
    logic par;
  } uae_err_t;
endpackage : uae_pkg

// >>> uae_checker.sv
`timescale 1ns/1ns
module uae_checker
  import uae_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // Line and events
  input wire logic channel2TransmitPinOe,
  input wire logic flowPinOe,
  input wire logic rxRequest,
  input wire logic txRequest,
  input wire logic collisionRequest
);
  logic apPend_ff;
  logic apWrite_ff;
  logic [7:0] apAddr_ff;
  logic [15:0] mode_ff;
  logic errClr_ff;
  logic modeOff;
  logic flowCts;
  logic rdRxb;
  logic rdSmr3;
  logic wrCtrl;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  assign modeOff = mode_ff[2:0] == MODE_DISABLED;
  assign flowCts = mode_ff[9:8] == FLOW_CTS;
  assign rdRxb = apPend_ff && !apWrite_ff && apAddr_ff == OFF_RXB;
  assign rdSmr3 = apPend_ff && !apWrite_ff && apAddr_ff == OFF_SMR3;
  assign wrCtrl = apPend_ff && apWrite_ff && apAddr_ff == OFF_CTRL;
  // Address phase shadow
  always_ff @(posedge clk) begin
    apPend_ff <= !reset && hsel && htrans[1] && hready;
    apWrite_ff <= hwrite;
    apAddr_ff <= haddr;
  end
  // Mode shadow, disabled out of reset
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_ff <= 16'h0000;
    end else if (apPend_ff && apWrite_ff && apAddr_ff == OFF_MODE) begin
      mode_ff <= hwdata[15:0];
    end
  end
  // Only the receive restart path; a disabled mode also clears the flags but is not tracked
  always_ff @(posedge clk) begin
    if (reset) begin
      errClr_ff <= 1'b1;
    end else if (wrCtrl && !hwdata[CTRL_RE]) begin
      errClr_ff <= 1'b1;
    end else if (rxRequest) begin
      errClr_ff <= 1'b0;
    end
  end
  property p_rx_pulse;
    rxRequest |=> !rxRequest;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("receive request longer than one cycle");
  property p_coll_pulse;
    collisionRequest |=> !collisionRequest;
  endproperty
  a_coll_pulse: assert property (p_coll_pulse)
    else $error("collision request longer than one cycle");
  property p_tx_stop_high;
    txRequest && !mode_ff[MODE_PINV] |-> !$past(channel2TransmitPinOe);
  endproperty
  a_tx_stop_high: assert property (p_tx_stop_high)
    else $error("transmit done without a high stop bit");
  property p_sum_or;
    rdRxb |-> hrdata[RXB_SUM] == |hrdata[RXB_PAR:RXB_OVR];
  endproperty
  a_sum_or: assert property (p_sum_or)
    else $error("error sum differs from its flags");
  property p_err_clear;
    rdRxb && errClr_ff |-> hrdata[RXB_FRM:RXB_OVR] == 2'h0;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("overrun or framing survived receive restart");
  property p_dl_zero;
    rdSmr3 && !mode_ff[MODE_SDA_DIGITAL_DELAY_SELECT] |-> hrdata[7:5] == SMR3_DL_RESET;
  endproperty
  a_dl_zero: assert property (p_dl_zero)
    else $error("delay bits not zero");
  property p_off_idle;
    modeOff && $past(modeOff) |-> !channel2TransmitPinOe;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("line driven while disabled");
  property p_cts_in;
    flowCts && $past(flowCts) |-> !flowPinOe;
  endproperty
  a_cts_in: assert property (p_cts_in)
    else $error("flow pin driven in input mode");
  c_rx: cover property (rxRequest);
  c_tx: cover property (txRequest);
  c_err: cover property (rdRxb && hrdata[RXB_SUM]);
  c_coll: cover property (collisionRequest);
endmodule : uae_checker

bind uae_uart uae_checker chk (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .channel2TransmitPinOe(channel2TransmitPinOe), .flowPinOe(flowPinOe),
  .rxRequest(rxRequest), .txRequest(txRequest), .collisionRequest(collisionRequest));

// >>> uae_remote.sv
`timescale 1ns/1ns
module uae_remote #(
  parameter int BIT_CYCLES = 16
) (
  // Clock
  input wire logic clk,
  // Serial line
  input wire logic lineIn,
  output logic lineOut,
  output logic clearToSendPin
);
  initial begin
    lineOut = 1'b1;
    clearToSendPin = 1'b1;
  end
  task set_cts(input logic v);
    @(posedge clk);
    clearToSendPin <= v;
  endtask : set_cts
  task send_bits(input logic [11:0] bits, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      lineOut <= bits[i];
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
    @(posedge clk);
    lineOut <= 1'b1;
  endtask : send_bits
  // Bounded hunt; all ones on timeout so the compare fails
  task get_bits(output logic [9:0] bits);
    int i;
    bits = 10'h3FF;
    for (i = 0; i < 20000 && lineIn !== 1'b0; i++) @(posedge clk);
    if (lineIn === 1'b0) begin
      repeat (BIT_CYCLES / 2) @(posedge clk);
      for (i = 0; i < 10; i++) begin
        bits[i] = lineIn;
        repeat (BIT_CYCLES) @(posedge clk);
      end
    end
  endtask : get_bits
endmodule : uae_remote

// >>> uart_async_errors_and_options_tb.sv
`timescale 1ns/1ns
module uart_async_errors_and_options_tb;
  import uae_pkg::*;
  logic clk, reset, hsel, hwrite, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic txOut, txOe, flowOut, flowOe, rxReq, txReq, collReq;
  logic txLine, rxLine, ctsLine, flowLevel;
  logic [9:0] frame;
  int num_errors, compares, rxCount, collCount;
  // Open-drain line with pull-up
  assign txLine = txOe ? txOut : 1'b1;
  assign flowLevel = flowOe ? flowOut : ctsLine;
  uae_uart dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .channel2ReceivePin(rxLine),
    .transferClockPin(1'b0), .channel2TransmitPinOut(txOut),
    .channel2TransmitPinOe(txOe), .flowPinIn(flowLevel), .flowPinOut(flowOut),
    .flowPinOe(flowOe), .rxRequest(rxReq), .txRequest(txReq), .collisionRequest(collReq));
  uae_remote #(.BIT_CYCLES(16)) remote (.clk(clk), .lineIn(txLine), .lineOut(rxLine),
    .clearToSendPin(ctsLine));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rxReq === 1'b1) rxCount <= rxCount + 1;
    if (collReq === 1'b1) collCount <= collCount + 1;
  end
  task report_and_stop;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task fail(input string msg);
    num_errors++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask : fail
  task check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    compares++;
    if ((got & mask) !== (exp & mask)) fail("compare mismatch");
  endtask : check
  task wait_ready;
    int i;
    @(posedge clk);
    for (i = 0; hreadyout !== 1'b1; i++) begin
      if (i > 50) begin
        fail("bus hang");
        report_and_stop;
      end
      @(posedge clk);
    end
  endtask : wait_ready
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    rd = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    bus(1'b0, a, 32'h0);
    check(rd, exp, mask);
  endtask : rd_chk
  task wait_rx(input int n);
    int i;
    for (i = 0; rxCount < n; i++) begin
      if (i > 5000) begin
        fail("no character");
        report_and_stop;
      end
      @(posedge clk);
    end
  endtask : wait_rx
  initial begin
    repeat (100000) @(posedge clk);
    fail("timeout");
    report_and_stop;
  end
  initial begin
    hsel = 1'b1;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    reset = 1'b1;
    num_errors = 0;
    compares = 0;
    rxCount = 0;
    collCount = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    wr(OFF_BRG, 32'h0);
    wr(OFF_MODE, {29'h0, MODE_UART8});
    wr(OFF_CTRL, 32'h3);
    remote.send_bits({3'h7, 8'hA5, 1'b0}, 10);
    wait_rx(1);
    rd_chk(OFF_RXB, 32'h00A5, 32'hF0FF);
    // Second and third characters unread
    remote.send_bits({3'h7, 8'h11, 1'b0}, 10);
    wait_rx(2);
    remote.send_bits({3'h7, 8'h22, 1'b0}, 10);
    repeat (40) @(posedge clk);
    check(32'(rxCount), 32'h2, 32'hFFFFFFFF);
    rd_chk(OFF_RXB, 32'h9022, 32'hF0FF);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_CTRL, 32'h3);
    rd_chk(OFF_RXB, 32'h0, 32'hF000);
    // Stop bit held low
    remote.send_bits({3'h0, 8'h3C, 1'b0}, 10);
    wait_rx(3);
    rd_chk(OFF_RXB, 32'hA03C, 32'hF0FF);
    wr(OFF_MODE, {29'h0, MODE_DISABLED});
    // Even parity, eight bits
    wr(OFF_MODE, 32'h85);
    rd_chk(OFF_RXB, 32'h0, 32'h3000);
    remote.send_bits({2'h3, 1'b1, 8'h03, 1'b0}, 11);
    wait_rx(4);
    rd_chk(OFF_RXB, 32'hC003, 32'hF0FF);
    rd_chk(OFF_RXB, 32'h0, 32'hF000);
    // Odd parity makes the same frame good
    wr(OFF_MODE, 32'hC5);
    remote.send_bits({2'h3, 1'b1, 8'h03, 1'b0}, 11);
    wait_rx(5);
    rd_chk(OFF_RXB, 32'h0003, 32'hF0FF);
    wr(OFF_MODE, 32'h805);
    remote.send_bits({3'h7, 8'h0F, 1'b0}, 10);
    wait_rx(6);
    rd_chk(OFF_RXB, 32'h00F0, 32'h00FF);
    // Flow pin as clear-to-send input
    wr(OFF_MODE, 32'h105);
    remote.set_cts(1'b1);
    wr(OFF_TXB, 32'h5A);
    repeat (64) @(posedge clk);
    check({31'h0, txLine}, 32'h1, 32'h1);
    remote.set_cts(1'b0);
    remote.get_bits(frame);
    check({22'h0, frame}, {22'h0, 1'b1, 8'h5A, 1'b0}, 32'h3FF);
    rd_chk(OFF_SMR3, 32'h0, 32'hE0);
    rd_chk(8'h20, 32'h0, 32'hFFFFFFFF);
    // Idle far end: only the start bit collides
    wr(OFF_MODE, 32'h2005);
    wr(OFF_TXB, 32'hFF);
    repeat (200) @(posedge clk);
    check(32'(collCount), 32'h1, 32'hFFFFFFFF);
    // Flow pin as request-to-send
    wr(OFF_MODE, 32'h205);
    @(posedge clk);
    check({31'h0, flowLevel}, 32'h0, 32'h1);
    wr(OFF_CTRL, 32'h1);
    @(posedge clk);
    check({31'h0, flowLevel}, 32'h1, 32'h1);
    wr(OFF_CTRL, 32'h3);
    // Abandon a frame in flight
    wr(OFF_TXB, 32'h00);
    repeat (40) @(posedge clk);
    wr(OFF_MODE, {29'h0, MODE_DISABLED});
    repeat (4) @(posedge clk);
    check({31'h0, txLine}, 32'h1, 32'h1);
    wr(OFF_TXB, 32'h55);
    // Back on: nothing left over may go out
    wr(OFF_MODE, 32'h5);
    repeat (40) @(posedge clk);
    check({31'h0, txLine}, 32'h1, 32'h1);
    report_and_stop;
  end
endmodule : uart_async_errors_and_options_tb
